// *** rbpc_consts.vh ***
// Constants for the reset, boot strap and pin configuration block
`ifndef RBPC_CONSTS_VH
`define RBPC_CONSTS_VH

// ****************************************
// Register offsets (word index on the plain port)
// ****************************************
`define RBPC_OFF_STATUS      4'h0
`define RBPC_OFF_BUFFERED_CLOCK_OUT_SEL    4'h1
`define RBPC_OFF_PA_SEL      4'h2
`define RBPC_OFF_PA_DIR      4'h3
`define RBPC_OFF_PA_DATA     4'h4
`define RBPC_OFF_PA_PIN      4'h5
`define RBPC_OFF_PE_SEL      4'h6
`define RBPC_OFF_PE_DIR      4'h7
`define RBPC_OFF_PE_DATA     4'h8
`define RBPC_OFF_PE_PIN      4'h9

// ****************************************
// Field positions and widths
// ****************************************
`define RBPC_STAT_BOOT_BIT   0
`define RBPC_STAT_RUN_BIT    1
`define RBPC_BUFFERED_CLOCK_OUT_SEL_W      5
`define RBPC_PE_W            2
`define RBPC_PA_W            8

// ****************************************
// Clock output select codes
// ****************************************
`define RBPC_BUFFERED_CLOCK_OUT_MASTER     5'h00
`define RBPC_BUFFERED_CLOCK_OUT_OSC        5'h01

// ****************************************
// Reset values and timing
// ****************************************
`define RBPC_BUFFERED_CLOCK_OUT_SEL_RST    5'h00
`define RBPC_SEL_RST         1'b0
`define RBPC_DIR_RST         1'b0
`define RBPC_RST_CYCLES      32

`endif

// *** rbpc_top.v ***
// Reset sequencer, boot strap latch, address pin muxing and clock output select
`timescale 1ns/1ps
`default_nettype none
`include "rbpc_consts.vh"

module rbpc_top #(
	parameter integer RST_CYCLES = `RBPC_RST_CYCLES   // Cycles from pin release to core release
) (
	input  wire        i_clock,              // 25 MHz system clock
	input  wire        i_sys_rst,            // Synchronous reset, active high
	input  wire        i_ext_rst_n,          // External reset pin, active low
	input  wire        i_trst_n,             // Debug port reset pin, active low
	input  wire        i_boot_select_strap,  // Boot strap pin
	input  wire        i_osc_in,             // Sampled oscillator clock
	input  wire        i_pll_master,         // Sampled PLL master clock
	input  wire        i_mem_req,            // External memory access request
	input  wire [15:0] i_mem_addr,           // Address of that access
	input  wire [1:0]  i_addr_mid_in,        // Pin levels of mid address lines
	input  wire [7:0]  i_addr_high_in,       // Pin levels of high address lines
	input  wire [3:0]  i_reg_addr,           // Register word index
	input  wire [15:0] i_reg_wdata,          // Register write data
	input  wire        i_reg_wr,             // Register write strobe
	input  wire        i_reg_rd,             // Register read strobe
	output reg  [15:0] o_reg_rdata,          // Read data, cycle after strobe
	output reg         o_core_rst,           // Internal reset, active high
	output reg         o_debug_rst,          // Debug port reset, active high
	output reg         o_boot_external,      // Latched boot mode
	output reg         o_buffered_clock_out, // Clock output pin
	output reg  [5:0]  o_addr_low,           // Low address lines
	output reg  [5:0]  o_addr_low_oe_n,      // Low lines enable, low drives
	output reg  [1:0]  o_addr_mid,           // Mid address lines
	output reg  [1:0]  o_addr_mid_oe_n,      // Mid lines enable, low drives
	output reg  [7:0]  o_addr_high,          // High address lines
	output reg  [7:0]  o_addr_high_oe_n      // High lines enable, low drives
);

	// ****************************************
	// Reset sequencer
	// ****************************************
	localparam [1:0] ST_HOLD  = 2'h0;   // External reset asserted
	localparam [1:0] ST_COUNT = 2'h1;   // Counting toward release
	localparam [1:0] ST_RUN   = 2'h2;   // Controller running

	localparam integer NPIN = `RBPC_PE_W + `RBPC_PA_W;  // Shared pins, port E first

	reg [1:0]  state_q;         // Sequencer state
	reg [31:0] cnt_q;           // Release delay counter
	reg        boot_q;          // Latched strap
	reg [15:0] addr_q;          // Last external access address
	reg [4:0]  buffered_clock_out_sel_q;      // Clock output select
	reg [NPIN-1:0] sel_q;       // 1 = general purpose function
	reg [NPIN-1:0] dir_q;       // 1 = output
	reg [NPIN-1:0] dat_q;       // Output data
	wire       pin_rst;         // Reset from pin or system
	wire [NPIN-1:0] pin_in;     // Shared pin levels
	wire [NPIN-1:0] pin_addr;   // Address bits for shared pins

	assign pin_rst  = i_sys_rst | ~i_ext_rst_n;
	assign pin_in   = {i_addr_high_in, i_addr_mid_in};
	assign pin_addr = addr_q[15:6];

	// Hold, count, then release in step with the clock
	always @(posedge i_clock) begin
		if (pin_rst) begin
			state_q <= ST_HOLD;
			cnt_q   <= 32'h00000000;
			boot_q  <= 1'b0;                      // No unknown mode before the first release
		end else begin
			case (state_q)
				ST_HOLD: begin
					// Strap is taken in the first cycle after release, so a slow strap
					// must be settled while the reset pin is still low
					boot_q  <= i_boot_select_strap;
					cnt_q   <= 32'h00000000;
					state_q <= ST_COUNT;
				end
				ST_COUNT: begin
					cnt_q <= cnt_q + 32'h00000001;
					if (cnt_q == RST_CYCLES - 1)
						state_q <= ST_RUN;
				end
				ST_RUN: begin
					state_q <= ST_RUN;
				end
				default: begin
					state_q <= ST_HOLD;
				end
			endcase
		end
	end

	// Registered reset outputs; core reset holds until counting ends
	always @(posedge i_clock) begin
		if (pin_rst) begin
			o_core_rst      <= 1'b1;
			o_boot_external <= 1'b0;
		end else begin
			o_core_rst      <= (state_q != ST_RUN);
			o_boot_external <= boot_q;
		end
	end

	// Debug reset follows only its own pin and the system reset, so a device-only reset keeps debug state
	always @(posedge i_clock) begin
		if (i_sys_rst)
			o_debug_rst <= 1'b1;
		else
			o_debug_rst <= ~i_trst_n;
	end

	// ****************************************
	// Register file
	// ****************************************
	// Writes are ignored while the core is in reset
	always @(posedge i_clock) begin
		if (o_core_rst) begin
			buffered_clock_out_sel_q <= `RBPC_BUFFERED_CLOCK_OUT_SEL_RST;
			sel_q      <= {NPIN{`RBPC_SEL_RST}};
			dir_q      <= {NPIN{`RBPC_DIR_RST}};
			dat_q      <= {NPIN{1'b0}};
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`RBPC_OFF_BUFFERED_CLOCK_OUT_SEL: buffered_clock_out_sel_q <= i_reg_wdata[4:0];
				`RBPC_OFF_PA_SEL:   sel_q[9:2] <= i_reg_wdata[7:0];
				`RBPC_OFF_PA_DIR:   dir_q[9:2] <= i_reg_wdata[7:0];
				`RBPC_OFF_PA_DATA:  dat_q[9:2] <= i_reg_wdata[7:0];
				`RBPC_OFF_PE_SEL:   sel_q[1:0] <= i_reg_wdata[1:0];
				`RBPC_OFF_PE_DIR:   dir_q[1:0] <= i_reg_wdata[1:0];
				`RBPC_OFF_PE_DATA:  dat_q[1:0] <= i_reg_wdata[1:0];
				default: begin
					// Read-only or unmapped: write dropped
				end
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge i_clock) begin
		if (i_sys_rst | ~i_reg_rd) begin
			o_reg_rdata <= 16'h0000;
		end else begin
			case (i_reg_addr)
				`RBPC_OFF_STATUS:   o_reg_rdata <= {14'h0000, ~o_core_rst, o_boot_external};
				`RBPC_OFF_BUFFERED_CLOCK_OUT_SEL: o_reg_rdata <= {11'h000, buffered_clock_out_sel_q};
				`RBPC_OFF_PA_SEL:   o_reg_rdata <= {8'h00, sel_q[9:2]};
				`RBPC_OFF_PA_DIR:   o_reg_rdata <= {8'h00, dir_q[9:2]};
				`RBPC_OFF_PA_DATA:  o_reg_rdata <= {8'h00, dat_q[9:2]};
				`RBPC_OFF_PA_PIN:   o_reg_rdata <= {8'h00, pin_in[9:2]};
				`RBPC_OFF_PE_SEL:   o_reg_rdata <= {14'h0000, sel_q[1:0]};
				`RBPC_OFF_PE_DIR:   o_reg_rdata <= {14'h0000, dir_q[1:0]};
				`RBPC_OFF_PE_DATA:  o_reg_rdata <= {14'h0000, dat_q[1:0]};
				`RBPC_OFF_PE_PIN:   o_reg_rdata <= {14'h0000, pin_in[1:0]};
				default:            o_reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ****************************************
	// Clock output
	// ****************************************
	// Sampled, so the pin carries the source delayed one cycle and limited to half the rate
	always @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_buffered_clock_out <= 1'b0;
		end else begin
			case (buffered_clock_out_sel_q)
				`RBPC_BUFFERED_CLOCK_OUT_MASTER: o_buffered_clock_out <= i_pll_master;
				`RBPC_BUFFERED_CLOCK_OUT_OSC:    o_buffered_clock_out <= i_osc_in;
				default:           o_buffered_clock_out <= 1'b0;          // Output off
			endcase
		end
	end

	// ****************************************
	// Address pins
	// ****************************************
	// Address of each access held on the bus until the next one
	always @(posedge i_clock) begin
		if (o_core_rst)
			addr_q <= 16'h0000;
		else if (i_mem_req)
			addr_q <= i_mem_addr;
	end

	// Low lines have no alternate function
	always @(posedge i_clock) begin
		if (o_core_rst) begin
			o_addr_low      <= 6'h00;
			o_addr_low_oe_n <= 6'h3F;
		end else begin
			o_addr_low      <= addr_q[5:0];
			o_addr_low_oe_n <= 6'h00;
		end
	end

	// Shared pins: address function unless selected as general purpose
	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : g_pin
			reg out_q;    // Pin level
			reg oen_q;    // Pin enable, low drives
			always @(posedge i_clock) begin
				if (o_core_rst) begin
					out_q <= 1'b0;
					oen_q <= 1'b1;
				end else if (sel_q[g]) begin
					out_q <= dat_q[g];
					oen_q <= ~dir_q[g];
				end else begin
					out_q <= pin_addr[g];
					oen_q <= 1'b0;
				end
			end
			if (g < `RBPC_PE_W) begin : g_mid
				always @* begin
					o_addr_mid[g]      = out_q;
					o_addr_mid_oe_n[g] = oen_q;
				end
			end else begin : g_high
				always @* begin
					o_addr_high[g-`RBPC_PE_W]      = out_q;
					o_addr_high_oe_n[g-`RBPC_PE_W] = oen_q;
				end
			end
		end
	endgenerate

endmodule // rbpc_top
`default_nettype wire

// *** rbpc_top_sva.sv ***
// Checker for reset release, boot latch and address pins
`timescale 1ns/1ps
`default_nettype none
module rbpc_top_sva #(parameter int RST_CYCLES = 32) (
	input wire logic        i_clock, i_sys_rst, i_ext_rst_n, i_trst_n, i_boot_select_strap,
	input wire logic        i_mem_req, o_core_rst, o_debug_rst, o_boot_external,
	input wire logic [15:0] i_mem_addr,
	input wire logic [5:0]  o_addr_low, o_addr_low_oe_n,
	input wire logic [1:0]  o_addr_mid_oe_n,
	input wire logic [7:0]  o_addr_high_oe_n
);
	localparam int REL = RST_CYCLES + 2; // Pin release sample to first running sample
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	property p_hold; !i_ext_rst_n |=> o_core_rst; endproperty
	a_hold: assert property (p_hold) else $error("core left reset");
	property p_tri; o_core_rst |=> &{o_addr_low_oe_n, o_addr_mid_oe_n, o_addr_high_oe_n}; endproperty
	a_tri: assert property (p_tri) else $error("pins driven in reset");
	property p_rel; $rose(i_ext_rst_n) |-> ##REL (!o_core_rst && $past(o_core_rst)); endproperty
	a_rel: assert property (p_rel) else $error("release count wrong");
	property p_boot; $rose(i_ext_rst_n) |-> ##4 o_boot_external == $past(i_boot_select_strap, 4); endproperty
	a_boot: assert property (p_boot) else $error("strap not latched");
	property p_keep; !o_core_rst && !$past(o_core_rst) |-> $stable(o_boot_external); endproperty
	a_keep: assert property (p_keep) else $error("boot mode moved");
	property p_dbg; 1'b1 |=> o_debug_rst == !$past(i_trst_n); endproperty
	a_dbg: assert property (p_dbg) else $error("debug reset wrong");
	property p_addr; i_mem_req && !o_core_rst |-> ##2 o_addr_low == 6'($past(i_mem_addr, 2)) && !o_addr_low_oe_n;
	endproperty
	a_addr: assert property (p_addr) else $error("address not driven");
	property p_dflt; $fell(o_core_rst) |-> ##[0:2] o_addr_mid_oe_n == 2'h0 && o_addr_high_oe_n == 8'h00; endproperty
	a_dflt: assert property (p_dflt) else $error("pins not address");
	c_rel: cover property ($rose(i_ext_rst_n));
	c_addr: cover property (i_mem_req && !o_core_rst);
	c_dbg: cover property ($fell(o_core_rst) && !o_debug_rst);
endmodule // rbpc_top_sva
`default_nettype wire

// *** rbpc_board.sv ***
// Board model: reset sources, strap, clock sources and pin loads
`timescale 1ns/1ps
`default_nettype none
module rbpc_board (
	input wire logic       i_clock, i_rst_req, i_keep_dbg, i_strap, // Reset request, keep debug, strap
	input wire logic [1:0] i_mid, i_mid_oe_n,                       // Device mid lines
	input wire logic [7:0] i_high, i_high_oe_n,                     // Device high lines
	output logic           o_ext_rst_n, o_trst_n, o_strap, o_osc, o_pll,
	output logic [1:0]     o_mid_in,                                // Resolved mid wire
	output logic [7:0]     o_high_in                                // Resolved high wire
);
	logic [1:0] div_q = 2'h0; // Oscillator at half, master at quarter rate
	always @(posedge i_clock) begin
		div_q <= div_q + 2'h1;
	end
	assign o_osc = div_q[0];
	assign o_pll = div_q[1];
	assign o_ext_rst_n = !i_rst_req;
	assign o_trst_n = !(i_rst_req && !i_keep_dbg); // Debug held only on full reset
	assign o_strap = i_strap;
	// Device wins where it drives; else the board load shows
	assign o_mid_in = i_mid & ~i_mid_oe_n;
	assign o_high_in = (i_high & ~i_high_oe_n) | (8'h3C & i_high_oe_n);
endmodule // rbpc_board
`default_nettype wire

// *** rbpc_top_tb_top.sv ***
// Testbench for the reset, boot strap and pin block
`timescale 1ns/1ps
`default_nettype none
`include "rbpc_consts.vh"
module rbpc_top_tb_top;
	logic        clk = 1'b0, srst = 1'b1, rreq = 1'b1, keep = 1'b0, strap = 1'b1;
	logic        mreq = 1'b0, wr = 1'b0, rd = 1'b0, osc_p, pll_p;
	logic [3:0]  ra = 4'h0;
	logic [15:0] maddr = 16'h0000, wd = 16'h0000;
	logic [4:0]  sel [3] = '{`RBPC_BUFFERED_CLOCK_OUT_OSC, 5'h1F, `RBPC_BUFFERED_CLOCK_OUT_MASTER}; // Each kind of select
	wire         ext_n, trst_n, bs, osc, pll, core_rst, dbg_rst, boot, cko;
	wire [15:0]  rdata;
	wire [5:0]   alo, alo_oe;
	wire [1:0]   ami, ami_oe, mid_in;
	wire [7:0]   ahi, ahi_oe, high_in;
	int          error_cnt = 0, samples_checked = 0;
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin // Source levels the design sampled
		osc_p <= osc;
		pll_p <= pll;
	end
	rbpc_top #(.RST_CYCLES(4)) rbpc_top_inst (.i_clock(clk), .i_sys_rst(srst), .i_ext_rst_n(ext_n),
		.i_trst_n(trst_n), .i_boot_select_strap(bs), .i_osc_in(osc), .i_pll_master(pll), .i_mem_req(mreq),
		.i_mem_addr(maddr), .i_addr_mid_in(mid_in), .i_addr_high_in(high_in), .i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_core_rst(core_rst),
		.o_debug_rst(dbg_rst), .o_boot_external(boot), .o_buffered_clock_out(cko), .o_addr_low(alo),
		.o_addr_low_oe_n(alo_oe), .o_addr_mid(ami), .o_addr_mid_oe_n(ami_oe), .o_addr_high(ahi),
		.o_addr_high_oe_n(ahi_oe));
	rbpc_board rbpc_board_inst (.i_clock(clk), .i_rst_req(rreq), .i_keep_dbg(keep), .i_strap(strap),
		.i_mid(ami), .i_mid_oe_n(ami_oe), .i_high(ahi), .i_high_oe_n(ahi_oe), .o_ext_rst_n(ext_n),
		.o_trst_n(trst_n), .o_strap(bs), .o_osc(osc), .o_pll(pll), .o_mid_in(mid_in), .o_high_in(high_in));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d); // One-cycle write strobe
		@(posedge clk);
		wr <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e); // Data only in the cycle after
		@(posedge clk);
		rd <= 1'b1;
		ra <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic wait_run; // Bounded wait for the core to leave reset
		int n;
		n = 0;
		while (core_rst !== 1'b0 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (core_rst !== 1'b0) begin
			error_cnt++;
			conclude();
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(negedge clk);
		chk({core_rst, dbg_rst}, 16'h0003);
		chk({alo_oe, ami_oe, ahi_oe}, 16'hFFFF);
		@(posedge clk);
		rreq <= 1'b0;
		wait_run();
		chk(boot, 16'h0001);
		rchk(`RBPC_OFF_STATUS, 16'h0003);
		@(posedge clk);
		strap <= 1'b0;
		wreg(4'hF, 16'hFFFF);
		foreach (sel[i]) rchk(4'hF - 4'(i) * 4'h7, 16'h0000); // Unmapped, PE_DATA, BUFFERED_CLOCK_OUT_SEL
		rchk(`RBPC_OFF_PA_SEL, 16'h0000);
		rchk(`RBPC_OFF_PE_SEL, 16'h0000);
		chk({alo_oe, ami_oe, ahi_oe}, 16'h0000);
		rchk(`RBPC_OFF_STATUS, 16'h0003);
		@(posedge clk);
		mreq <= 1'b1;
		maddr <= 16'hA5C3;
		@(posedge clk);
		maddr <= 16'h5A3C;
		@(posedge clk);
		mreq <= 1'b0;
		@(negedge clk);
		chk({ahi, ami, alo}, 16'hA5C3);
		@(negedge clk);
		chk({ahi, ami, alo}, 16'h5A3C);
		wreg(`RBPC_OFF_PA_SEL, 16'h00FF);
		wreg(`RBPC_OFF_PA_DIR, 16'h000F);
		wreg(`RBPC_OFF_PA_DATA, 16'h00A5);
		wreg(`RBPC_OFF_PE_SEL, 16'h0003);
		wreg(`RBPC_OFF_PE_DIR, 16'h0001);
		wreg(`RBPC_OFF_PE_DATA, 16'h0001);
		repeat (2) @(negedge clk);
		chk({ahi_oe, ahi[3:0], ami_oe}, {8'hF0, 4'h5, 2'h2});
		rchk(`RBPC_OFF_PA_PIN, 16'h0035);
		rchk(`RBPC_OFF_PE_PIN, 16'h0001);
		foreach (sel[i]) begin
			wreg(`RBPC_OFF_BUFFERED_CLOCK_OUT_SEL, 16'(sel[i]));
			rchk(`RBPC_OFF_BUFFERED_CLOCK_OUT_SEL, 16'(sel[i]));
			repeat (4) begin
				@(negedge clk);
				chk(cko, sel[i] == `RBPC_BUFFERED_CLOCK_OUT_MASTER ? pll_p : sel[i] == `RBPC_BUFFERED_CLOCK_OUT_OSC ? osc_p : 1'b0);
			end
		end
		@(posedge clk);
		keep <= 1'b1;
		rreq <= 1'b1;
		repeat (3) @(negedge clk);
		chk({core_rst, dbg_rst, ahi_oe}, {2'h2, 8'hFF});
		@(posedge clk);
		rreq <= 1'b0;
		wait_run();
		rchk(`RBPC_OFF_PA_SEL, 16'h0000);
		chk({boot, ami_oe, ahi_oe}, 16'h0000);
		conclude();
	end
endmodule // rbpc_top_tb_top
bind rbpc_top rbpc_top_sva #(.RST_CYCLES(RST_CYCLES)) rbpc_top_sva_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_ext_rst_n(i_ext_rst_n), .i_trst_n(i_trst_n), .i_boot_select_strap(i_boot_select_strap),
	.i_mem_req(i_mem_req), .o_core_rst(o_core_rst), .o_debug_rst(o_debug_rst), .o_boot_external(o_boot_external),
	.i_mem_addr(i_mem_addr), .o_addr_low(o_addr_low), .o_addr_low_oe_n(o_addr_low_oe_n),
	.o_addr_mid_oe_n(o_addr_mid_oe_n), .o_addr_high_oe_n(o_addr_high_oe_n));
`default_nettype wire
